// >>> logic/ts_device.sv
// Sensor-side two-wire slave engine
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module ts_device
  import tsense_pkg::*;
#(
  parameter bit VARIANT_B      = 1'b0,
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  input  wire logic   clock,
  input  wire logic   rst_b,
  tsense_if.dev       bus,
  output logic [7:0]  reg_ptr,
  input  wire logic [15:0] reg_rdata,
  output logic        reg_wr,
  output logic [7:0]  reg_wdata,
  output logic        sw_reset,
  input  wire logic   alert_out_mode,
  input  wire logic   alert_active,
  input  wire logic   alert_high,
  output logic        alert_clear,
  output logic        hs_mode,
  output logic        timeout_en
);
  localparam logic [6:0]      MY_ADDR = VARIANT_B ? ADDR_VAR_B : ADDR_VAR_A;
  localparam logic [TO_W-1:0] TO_LAST = TO_W'(TIMEOUT_CYCLES - 1);

  typedef struct packed {
    dev_st_t         st;
    logic [7:0]      sh;
    logic [3:0]      cnt;
    logic            first;
    logic [1:0]      nbyte;
    logic            rd;
    logic            gc;
    logic            ara;
    logic [7:0]      ptr;
    logic            to_en;
    logic            hs;
    logic            busy;
    logic            scl_p;
    logic            sda_p;
    logic [TO_W-1:0] tcnt;
    logic            sda_oe;
    logic            wr;
    logic [7:0]      wdata;
    logic            swr;
    logic            aclr;
  } dev_s_t;

  dev_s_t s_q;
  dev_s_t s_d;
  logic   scl_s;
  logic   sda_s;
  logic   rise;
  logic   fall;
  logic   start;
  logic   stop;

  pin_sync u_scl (.clock(clock), .rst_b(rst_b), .pin(bus.scl), .level(scl_s));
  pin_sync u_sda (.clock(clock), .rst_b(rst_b), .pin(bus.sda), .level(sda_s));

  // ****************************************
  // Bus conditions
  // ****************************************
  assign rise  = !s_q.scl_p && scl_s;
  assign fall  = s_q.scl_p && !scl_s;
  assign start = s_q.scl_p && scl_s && s_q.sda_p && !sda_s; // [R01]
  assign stop  = s_q.scl_p && scl_s && !s_q.sda_p && sda_s; // [R02]

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d       = s_q;
    s_d.wr    = 1'b0;
    s_d.swr   = 1'b0;
    s_d.aclr  = 1'b0;
    s_d.scl_p = scl_s;
    s_d.sda_p = sda_s;
    // Either line low counts, so a stuck master clock is caught too
    if (s_q.busy && s_q.to_en && (!scl_s || !sda_s)) begin // [R11]
      s_d.tcnt = s_q.tcnt + 1'b1;
    end else begin
      s_d.tcnt = '0;
    end
    if (start) begin
      s_d.st     = D_RX; // [R02]
      s_d.cnt    = 4'h0;
      s_d.first  = 1'b1;
      s_d.busy   = 1'b1;
      s_d.sda_oe = 1'b0;
      s_d.rd     = 1'b0;
      s_d.gc     = 1'b0;
      s_d.ara    = 1'b0;
      s_d.nbyte  = 2'h0;
      s_d.tcnt   = '0;
    end else if (stop) begin
      s_d.st     = D_IDLE; // [R02]
      s_d.busy   = 1'b0;
      s_d.hs     = 1'b0; // [R15]
      s_d.sda_oe = 1'b0;
      s_d.tcnt   = '0;
    end else if (s_q.tcnt >= TO_LAST) begin
      s_d.st     = D_IDLE; // [R12]
      s_d.busy   = 1'b0;
      s_d.sda_oe = 1'b0;
      s_d.tcnt   = '0;
    end else begin
      case (s_q.st)
        D_RX: begin
          if (rise) begin
            s_d.sh  = {s_q.sh[6:0], sda_s}; // [R23]
            s_d.cnt = s_q.cnt + 4'h1;
          end else if (fall && s_q.cnt == 4'h8) begin
            s_d.cnt    = 4'h0;
            s_d.st     = D_ACK; // [R04]
            s_d.sda_oe = 1'b1;
            if (s_q.first) begin
              s_d.first = 1'b0;
              if (s_q.sh[7:1] == MY_ADDR) begin // [R06]
                s_d.rd = s_q.sh[0];
                s_d.sh = reg_rdata[15:8]; // [R08] [R10]
              end else if (s_q.sh == {GCALL_ADDR, 1'b0}) begin
                s_d.gc = 1'b1; // [R16]
              end else if (s_q.sh == ARA_BYTE && alert_out_mode && alert_active) begin // [R19]
                s_d.rd  = 1'b1; // [R20]
                s_d.ara = 1'b1;
                s_d.sh  = {MY_ADDR, alert_high}; // [R21]
              end else begin
                s_d.st     = D_IDLE;
                s_d.sda_oe = 1'b0;
                if (s_q.sh[7:3] == HS_CODE_TOP) begin
                  s_d.hs = 1'b1; // [R14]
                end
              end
            end else begin
              s_d.nbyte = (s_q.nbyte == 2'h2) ? 2'h2 : s_q.nbyte + 2'h1; // [R03]
              if (s_q.gc) begin
                if (s_q.nbyte == 2'h0 && s_q.sh == GC_RESET_BYTE) begin
                  s_d.swr   = 1'b1; // [R16] [R17]
                  s_d.to_en = TO_EN_RESET;
                  s_d.ptr   = PTR_RESET;
                end
              end else if (s_q.nbyte == 2'h0) begin
                s_d.ptr = s_q.sh; // [R07]
              end else begin
                s_d.wr    = 1'b1; // [R07]
                s_d.wdata = s_q.sh;
                if (s_q.ptr == PTR_SW_RESET) begin
                  s_d.swr   = 1'b1; // [R18] [R17]
                  s_d.to_en = TO_EN_RESET;
                  s_d.ptr   = PTR_RESET;
                end else if (s_q.ptr == PTR_CONSEC) begin
                  s_d.to_en = s_q.sh[TO_EN_BIT]; // [R11]
                end
              end
            end
          end
        end
        D_ACK: begin
          if (fall) begin
            if (s_q.rd) begin
              s_d.st     = D_TX;
              s_d.sda_oe = ~s_q.sh[7];
            end else begin
              s_d.st     = D_RX;
              s_d.sda_oe = 1'b0;
            end
          end
        end
        D_TX: begin
          if (rise) begin
            s_d.cnt = s_q.cnt + 4'h1;
            if (s_q.ara && s_q.sh[7] && !sda_s) begin
              s_d.st     = D_IDLE; // [R22]
              s_d.sda_oe = 1'b0;
            end
          end else if (fall) begin
            if (s_q.cnt == 4'h8) begin
              s_d.st     = D_MACK;
              s_d.cnt    = 4'h0;
              s_d.sda_oe = 1'b0;
            end else begin
              s_d.sh     = {s_q.sh[6:0], 1'b0}; // [R23]
              s_d.sda_oe = ~s_q.sh[6];
            end
          end
        end
        D_MACK: begin
          if (rise) begin
            if (sda_s) begin
              s_d.st   = D_IDLE; // [R05]
              s_d.aclr = s_q.ara; // [R22]
            end else begin
              s_d.cnt = 4'h1;
              s_d.sh  = reg_rdata[7:0]; // [R10]
            end
          end else if (fall && s_q.cnt == 4'h1) begin
            s_d.st     = D_TX;
            s_d.cnt    = 4'h0;
            s_d.sda_oe = ~s_q.sh[7];
          end
        end
        default: begin
          s_d.st = D_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_q       <= '0;
      s_q.st    <= D_IDLE;
      s_q.ptr   <= PTR_RESET;
      s_q.to_en <= TO_EN_RESET; // [R11]
      s_q.scl_p <= 1'b1;
      s_q.sda_p <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign bus.d_scl_o  = 1'b0;
  assign bus.d_scl_oe = 1'b0;
  assign bus.d_sda_o  = 1'b0;
  assign bus.d_sda_oe = s_q.sda_oe;
  assign reg_ptr      = s_q.ptr;
  assign reg_wr       = s_q.wr;
  assign reg_wdata    = s_q.wdata;
  assign sw_reset     = s_q.swr;
  assign alert_clear  = s_q.aclr;
  assign hs_mode      = s_q.hs;
  assign timeout_en   = s_q.to_en;
endmodule

// >>> logic/tsense_pkg.sv
// Shared constants and types for the two-wire temperature sensor link
// Summary of operation
// R01 - Start: data falls while clock is high
// R02 - Stop or repeated start ends transfer
// R03 - Master chooses byte count, no limit
// R04 - Receiver drives ninth bit low
// R05 - Master ends read with not-acknowledge
// R06 - First byte is address plus direction
// R07 - First written byte loads pointer, rest write
// R08 - Pointer kept across transactions
// R09 - Pointer write then restart to read
// R10 - Two-byte read sends high byte first
// R11 - Timeout enable bit, set after reset
// R12 - Clock or data low too long resets
// R13 - Master keeps clock at 1 kHz or faster
// R14 - Master code not acknowledged, enters fast filters
// R15 - Fast mode lasts until stop
// R16 - General call second byte 06h resets
// R17 - Software reset restores all power-on state
// R18 - Writing pointer Software_reset_trigger resets too
// R19 - Alert answer only in alert pin mode
// R20 - Alert answer acknowledged, own address sent
// R21 - Eighth returned bit tells limit direction
// R22 - Arbitrate; winner clears alert, loser keeps
// R23 - Bytes shifted most significant bit first
package tsense_pkg;

  // ****************************************
  // Addresses and command bytes
  // ****************************************
  localparam logic [6:0] ADDR_VAR_A    = 7'h4c;
  localparam logic [6:0] ADDR_VAR_B    = 7'h4d;
  localparam logic [6:0] GCALL_ADDR    = 7'h00;
  localparam logic [7:0] ARA_BYTE      = 8'h19;
  localparam logic [4:0] HS_CODE_TOP   = 5'h01;
  localparam logic [7:0] GC_RESET_BYTE = 8'h06;
  localparam logic [7:0] PTR_SW_RESET  = 8'hfc;
  localparam logic [7:0] PTR_CONSEC    = 8'h22;
  localparam int         TO_EN_BIT     = 7;
  localparam logic [7:0] PTR_RESET     = 8'h00;
  localparam logic       TO_EN_RESET   = 1'b1;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ      = 40_000_000;
  localparam int TIMEOUT_MS  = 30;
  localparam int TIMEOUT_CYC = CLK_HZ / 1000 * TIMEOUT_MS;
  localparam int TO_W        = 21;
  localparam int MIN_SCL_HZ  = 1000;
  localparam int SCL_HZ      = 400_000;
  localparam int QTR_CYC     = CLK_HZ / (4 * SCL_HZ);
  localparam int QC_W        = 5;

  // ****************************************
  // Host control port map
  // ****************************************
  localparam logic [1:0] OFF_CTRL   = 2'h0;
  localparam logic [1:0] OFF_TX     = 2'h1;
  localparam logic [1:0] OFF_RX     = 2'h2;
  localparam logic [1:0] OFF_STATUS = 2'h3;
  localparam int CTL_START = 0;
  localparam int CTL_STOP  = 1;
  localparam int CTL_READ  = 2;
  localparam int CTL_NACK  = 3;
  localparam int STS_BUSY  = 0;
  localparam int STS_NACK  = 1;

  typedef enum logic [4:0] {
    D_IDLE = 5'h01, D_RX = 5'h02, D_ACK = 5'h04, D_TX = 5'h08, D_MACK = 5'h10
  } dev_st_t;

  typedef enum logic [3:0] {
    H_IDLE = 4'h1, H_START = 4'h2, H_BIT = 4'h4, H_STOP = 4'h8
  } host_st_t;

endpackage

// >>> logic/tsense_if.sv
// Two-wire link between bus master and sensor slave
`timescale 1ns/1ps
interface tsense_if;
  logic scl;
  logic sda;
  logic h_scl_o;
  logic h_scl_oe;
  logic h_sda_o;
  logic h_sda_oe;
  logic d_scl_o;
  logic d_scl_oe;
  logic d_sda_o;
  logic d_sda_oe;

  // Open-drain wired-and with pull-up
  assign scl = ~(h_scl_oe & ~h_scl_o) & ~(d_scl_oe & ~d_scl_o);
  assign sda = ~(h_sda_oe & ~h_sda_o) & ~(d_sda_oe & ~d_sda_o);

  modport dev (input scl, input sda, output d_scl_o, output d_scl_oe,
               output d_sda_o, output d_sda_oe);
  modport host (input scl, input sda, output h_scl_o, output h_scl_oe,
                output h_sda_o, output h_sda_oe);
endinterface

// >>> logic/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic pin,
  output logic      level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lv;
  } sync_t;

  sync_t s_q;
  sync_t s_d;

  // Idle bus level is high
  always_comb begin
    s_d    = s_q;
    s_d.s1 = pin;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    if (s_q.s2 == s_q.s3) begin
      s_d.lv = s_q.s3;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, lv: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign level = s_q.lv;
endmodule

// >>> logic/ts_host.sv
// Bus-master end driving the two-wire link
`timescale 1ns/1ps
module ts_host
  import tsense_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_b,
  tsense_if.host          bus,
  input  wire logic [1:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic [7:0]      rdata
);
  localparam logic [QC_W-1:0] QTR_LAST = QC_W'(QTR_CYC - 1);

  typedef struct packed {
    host_st_t        st;
    logic [QC_W-1:0] qc;
    logic [1:0]      ph;
    logic [3:0]      bitn;
    logic [7:0]      sh;
    logic [7:0]      tx;
    logic [7:0]      rx;
    logic [3:0]      cmd;
    logic            samp;
    logic            nack;
    logic            hold;
    logic            scl_oe;
    logic            sda_oe;
    logic [7:0]      rdata;
  } host_s_t;

  host_s_t s_q;
  host_s_t s_d;
  logic    sda_s;
  logic    tick;
  logic    drv;

  pin_sync u_sda (.clock(clock), .rst_b(rst_b), .pin(bus.sda), .level(sda_s));

  assign tick = (s_q.qc == QTR_LAST);

  always_comb begin
    s_d    = s_q;
    s_d.qc = (tick || s_q.st == H_IDLE) ? '0 : s_q.qc + 1'b1;
    // ****************************************
    // Control port
    // ****************************************
    if (rd) begin
      if (addr == OFF_CTRL) begin
        s_d.rdata = {4'h0, s_q.cmd};
      end else if (addr == OFF_TX) begin
        s_d.rdata = s_q.tx;
      end else if (addr == OFF_RX) begin
        s_d.rdata = s_q.rx;
      end else begin
        s_d.rdata = {6'h00, s_q.nack, s_q.st != H_IDLE};
      end
    end
    if (wr && addr == OFF_TX) begin
      s_d.tx = wdata;
    end
    // Commands while busy are dropped; software polls the busy bit
    if (wr && addr == OFF_CTRL && s_q.st == H_IDLE) begin
      s_d.cmd  = wdata[3:0];
      s_d.sh   = s_q.tx;
      s_d.bitn = 4'h0;
      s_d.ph   = 2'h0;
      s_d.qc   = '0;
      s_d.st   = wdata[CTL_START] ? H_START : H_BIT; // [R01]
    end else if (tick) begin
      // ****************************************
      // Bit sequencer
      // ****************************************
      s_d.ph = s_q.ph + 2'h1;
      case (s_q.st)
        H_START: begin
          if (s_q.ph == 2'h3) begin
            s_d.st = H_BIT;
          end
        end
        H_BIT: begin
          if (s_q.ph == 2'h2) begin
            s_d.samp = sda_s;
          end else if (s_q.ph == 2'h3) begin
            if (s_q.bitn == 4'h8) begin
              if (s_q.cmd[CTL_READ]) begin
                s_d.rx = s_q.sh;
              end else begin
                s_d.nack = s_q.samp; // [R04]
              end
              s_d.hold = !s_q.cmd[CTL_STOP];
              s_d.st   = s_q.cmd[CTL_STOP] ? H_STOP : H_IDLE; // [R02] [R03]
            end else begin
              s_d.sh   = {s_q.sh[6:0], s_q.samp}; // [R23]
              s_d.bitn = s_q.bitn + 4'h1;
            end
          end
        end
        H_STOP: begin
          if (s_q.ph == 2'h3) begin
            s_d.st   = H_IDLE;
            s_d.hold = 1'b0;
          end
        end
        default: begin
          s_d.st = H_IDLE;
        end
      endcase
    end
    // ****************************************
    // Pin levels for the coming quarter
    // ****************************************
    if (s_d.bitn < 4'h8) begin
      drv = s_d.cmd[CTL_READ] ? 1'b0 : ~s_d.sh[7]; // [R23]
    end else begin
      drv = s_d.cmd[CTL_READ] ? ~s_d.cmd[CTL_NACK] : 1'b0; // [R04] [R05]
    end
    case (s_d.st)
      H_START: begin
        s_d.scl_oe = (s_d.ph == 2'h0) || (s_d.ph == 2'h3);
        s_d.sda_oe = s_d.ph[1]; // [R01]
      end
      H_BIT: begin
        s_d.scl_oe = (s_d.ph == 2'h0) || (s_d.ph == 2'h3); // [R13]
        s_d.sda_oe = drv;
      end
      H_STOP: begin
        s_d.scl_oe = (s_d.ph == 2'h0);
        s_d.sda_oe = !s_d.ph[1]; // [R02]
      end
      default: begin
        s_d.scl_oe = s_d.hold;
        s_d.sda_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_q    <= '0;
      s_q.st <= H_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.h_scl_o  = 1'b0;
  assign bus.h_scl_oe = s_q.scl_oe;
  assign bus.h_sda_o  = 1'b0;
  assign bus.h_sda_oe = s_q.sda_oe;
  assign rdata        = s_q.rdata;
endmodule

// >>> dv/tsense_checker.sv
// Concurrent checks on the two-wire link and sensor outputs
`timescale 1ns/1ps
module tsense_checker
  import tsense_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = 500
) (
  input wire logic       clock,
  input wire logic       rst_b,
  input wire logic       scl,
  input wire logic       sda,
  input wire logic       d_sda_oe,
  input wire logic [7:0] reg_ptr,
  input wire logic       reg_wr,
  input wire logic       sw_reset,
  input wire logic       alert_clear,
  input wire logic       hs_mode,
  input wire logic       timeout_en
);
  int low_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      low_q <= 0;
    end else begin
      low_q <= (scl && sda) ? 0 : low_q + 1;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  // ********
  // Link rules
  // ********
  a_ack_steady: assert property (scl && $past(scl) |-> $stable(d_sda_oe))
    else $error("device data drive moved while clock high");
  a_ack_rise: assert property ($rose(d_sda_oe) |-> !scl)
    else $error("device drive began with clock high");
  a_start_free: assert property (scl && $fell(sda) |-> !d_sda_oe [*8])
    else $error("device drove data right after start");
  a_hs_stop: assert property (scl && $rose(sda) |-> ##[1:8] !hs_mode)
    else $error("fast mode kept after stop");
  // Margin of 8 covers the input filter lag
  a_tmo_release: assert property (timeout_en && low_q > TIMEOUT_CYCLES + 8
                                  |-> !d_sda_oe)
    else $error("line still driven after bus timeout");
  a_reset_state: assert property (sw_reset |-> ##[0:2]
                                  (reg_ptr == PTR_RESET && timeout_en))
    else $error("software reset left state behind");
  a_clear_pulse: assert property (alert_clear |=> !alert_clear)
    else $error("alert clear longer than one cycle");
  a_wr_ack: assert property (reg_wr |-> ##[0:1] d_sda_oe)
    else $error("register write without acknowledge");

  c_swr: cover property (sw_reset);
  c_clr: cover property (alert_clear);
  c_hs: cover property (hs_mode);
endmodule

// >>> dv/tb_top.sv
// Self-checking bench joining bus master and sensor ends
`timescale 1ns/1ps
module tb_top
  import tsense_pkg::*;
;
  // Must exceed the longest normal low stretch, a zero address plus a zero-led byte
  localparam int TO = 2000;
  logic        clock;
  logic        rst_b;
  logic [1:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic [7:0]  reg_ptr;
  logic [15:0] reg_rdata;
  logic        reg_wr;
  logic [7:0]  reg_wdata;
  logic        sw_reset;
  logic        alert_out_mode;
  logic        alert_active;
  logic        alert_high;
  logic        alert_clear;
  logic        hs_mode;
  logic        timeout_en;
  logic [7:0]  wd_last;
  logic [7:0]  first_q;
  logic [7:0]  sh_q;
  logic        sda_q;
  logic        scl_q;
  logic        n;
  logic [7:0]  b;
  logic [15:0] w;
  int          nbit = 8;
  int          errors = 0;
  int          samples_checked = 0;
  int          swr = 0;
  int          clr = 0;
  int          starts = 0;

  // Register content follows the pointer so reads prove which one was chosen
  assign reg_rdata = {reg_ptr ^ 8'ha5, reg_ptr};

  tsense_if bus_if ();
  ts_host ts_host_inst (.clock(clock), .rst_b(rst_b), .bus(bus_if.host), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  ts_device #(.VARIANT_B(1'b0), .TIMEOUT_CYCLES(TO)) ts_device_inst (.clock(clock),
    .rst_b(rst_b), .bus(bus_if.dev), .reg_ptr(reg_ptr), .reg_rdata(reg_rdata),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .sw_reset(sw_reset),
    .alert_out_mode(alert_out_mode), .alert_active(alert_active),
    .alert_high(alert_high), .alert_clear(alert_clear), .hs_mode(hs_mode),
    .timeout_en(timeout_en));
  tsense_checker #(.TIMEOUT_CYCLES(TO)) tsense_checker_inst (.clock(clock),
    .rst_b(rst_b), .scl(bus_if.scl), .sda(bus_if.sda), .d_sda_oe(bus_if.d_sda_oe),
    .reg_ptr(reg_ptr), .reg_wr(reg_wr), .sw_reset(sw_reset),
    .alert_clear(alert_clear), .hs_mode(hs_mode), .timeout_en(timeout_en));

  // ********
  // Wire and pulse monitor
  // ********
  always @(posedge clock) begin
    sda_q <= bus_if.sda;
    scl_q <= bus_if.scl;
    if (sw_reset === 1'b1) swr <= swr + 1;
    if (alert_clear === 1'b1) clr <= clr + 1;
    if (reg_wr === 1'b1) wd_last <= reg_wdata;
    if (bus_if.scl && sda_q && !bus_if.sda) begin
      starts <= starts + 1;
      nbit <= 0;
    end
    if (bus_if.scl && !scl_q && nbit < 8) begin
      sh_q <= {sh_q[6:0], bus_if.sda};
      nbit <= nbit + 1;
      if (nbit == 7) first_q <= {sh_q[6:0], bus_if.sda};
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic hw(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic hr(input logic [1:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    d = rdata;
  endtask

  // Control bits: 1 start, 2 stop, 4 read, 8 send not-acknowledge
  task automatic xfer(input logic [3:0] c, input logic [7:0] t, output logic nk);
    logic [7:0] s;
    int i;
    hw(OFF_TX, t);
    hw(OFF_CTRL, {4'h0, c});
    s = 8'h01;
    for (i = 0; i < 3000 && s[STS_BUSY] !== 1'b0; i++) hr(OFF_STATUS, s);
    if (s[STS_BUSY] !== 1'b0) chk("busy", 16'h0, 16'h1);
    nk = s[STS_NACK];
  endtask

  task automatic wreg(input logic [7:0] p, input logic [7:0] d);
    xfer(4'h1, {ADDR_VAR_A, 1'b0}, n);
    xfer(4'h0, p, n);
    xfer(4'h2, d, n);
  endtask

  task automatic rd2(output logic [15:0] v);
    xfer(4'h1, {ADDR_VAR_A, 1'b1}, n);
    xfer(4'h4, 8'h00, n);
    hr(OFF_RX, v[15:8]);
    xfer(4'he, 8'h00, n);
    hr(OFF_RX, v[7:0]);
  endtask

  task automatic stop_test();
    if (errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ********
  // Scenarios
  // ********
  task automatic t_write();
    wreg(PTR_CONSEC, 8'h01);
    chk("pointer", {8'h0, PTR_CONSEC}, {8'h0, reg_ptr});
    chk("wdata", 16'h01, {8'h0, wd_last});
    chk("to off", 16'h0, {15'h0, timeout_en});
    wreg(PTR_CONSEC, 8'h80);
    chk("to on", 16'h1, {15'h0, timeout_en});
  endtask

  task automatic t_read();
    int k;
    xfer(4'h1, {ADDR_VAR_A, 1'b0}, n);
    xfer(4'h0, 8'h05, n);
    for (k = 0; k < 2; k++) begin
      rd2(w);
      chk("word", {8'h05 ^ 8'ha5, 8'h05}, w);
    end
  endtask

  task automatic t_addr();
    int s0;
    s0 = starts;
    xfer(4'h3, {ADDR_VAR_B, 1'b0}, n);
    chk("other addr", 16'h1, {15'h0, n});
    chk("starts", 16'(s0 + 1), 16'(starts));
    chk("wire byte", {8'h0, ADDR_VAR_B, 1'b0}, {8'h0, first_q});
    chk("idle", 16'h3, {14'h0, bus_if.scl, bus_if.sda});
  endtask

  task automatic t_hs();
    xfer(4'h1, 8'h0b, n);
    chk("hs nack", 16'h1, {15'h0, n});
    chk("hs on", 16'h1, {15'h0, hs_mode});
    xfer(4'h3, {ADDR_VAR_A, 1'b0}, n);
    chk("hs addr", 16'h0, {15'h0, n});
    repeat (8) @(posedge clock);
    chk("hs off", 16'h0, {15'h0, hs_mode});
  endtask

  task automatic t_reset();
    int k;
    int s0;
    wreg(PTR_CONSEC, 8'h00);
    for (k = 0; k < 2; k++) begin
      s0 = swr;
      xfer(4'h1, 8'h00, n);
      chk("gc ack", 16'h0, {15'h0, n});
      xfer(4'h2, GC_RESET_BYTE - 8'h01 + 8'(k), n);
      chk("gc reset", 16'(k), 16'(swr - s0));
    end
    chk("gc ptr", {8'h0, PTR_RESET}, {8'h0, reg_ptr});
    chk("gc to", {15'h0, TO_EN_RESET}, {15'h0, timeout_en});
    s0 = swr;
    wreg(PTR_SW_RESET, 8'h5a);
    chk("fc reset", 16'h1, 16'(swr - s0));
    chk("fc ptr", {8'h0, PTR_RESET}, {8'h0, reg_ptr});
  endtask

  task automatic t_alert();
    int k;
    int s0;
    @(posedge clock);
    alert_active <= 1'b1;
    xfer(4'h3, ARA_BYTE, n);
    chk("ara off", 16'h1, {15'h0, n});
    @(posedge clock);
    alert_out_mode <= 1'b1;
    for (k = 0; k < 2; k++) begin
      @(posedge clock);
      alert_high <= k[0];
      s0 = clr;
      xfer(4'h1, ARA_BYTE, n);
      chk("ara ack", 16'h0, {15'h0, n});
      xfer(4'he, 8'h00, n);
      hr(OFF_RX, b);
      chk("ara addr", {8'h0, ADDR_VAR_A, k[0]}, {8'h0, b});
      chk("alert clear", 16'h1, 16'(clr - s0));
    end
    @(posedge clock);
    alert_active <= 1'b0;
  endtask

  // Host keeps the clock low after a byte without stop, which starves the link
  task automatic t_tmo();
    int k;
    for (k = 0; k < 2; k++) begin
      wreg(PTR_CONSEC, {k[0], 7'h00});
      xfer(4'h1, {ADDR_VAR_A, 1'b0}, n);
      repeat (TO + 200) @(posedge clock);
      // No new start: only a slave still mid-transfer takes this byte
      xfer(4'h2, 8'h01, n);
      chk("timeout", 16'(k), {15'h0, n});
    end
  endtask

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  initial begin
    repeat (90000) @(posedge clock);
    errors++;
    stop_test();
  end

  initial begin
    rst_b = 1'b0;
    addr = 2'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    alert_out_mode = 1'b0;
    alert_active = 1'b0;
    alert_high = 1'b0;
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    repeat (10) @(posedge clock);
    t_write();
    t_read();
    t_addr();
    t_hs();
    t_reset();
    t_alert();
    t_tmo();
    stop_test();
  end
endmodule
